//--- logic/iars_pkg.sv
package iars_pkg;

  // ----------------------------------------------------------------
  // Bus and register widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;  // Host byte address width.
  localparam int DATA_W = 16;  // Host data width.
  localparam int SOCK_N = 8;   // Number of sockets that have a summary bit.

  // ----------------------------------------------------------------
  // Host addresses
  // ----------------------------------------------------------------
  // Mode register, pointer-access mode address.
  localparam logic [ADDR_W-1:0] MODE_PTR_ADDR = 17'h08000;
  // Pointer register, high byte at this even address.
  localparam logic [ADDR_W-1:0] PTR_ADDR      = 17'h08002;
  // Data window, high byte at this even address.
  localparam logic [ADDR_W-1:0] WIN_ADDR      = 17'h08004;
  // Direct mode maps host addresses below this one to register offsets.
  localparam logic [ADDR_W-1:0] DIRECT_SPAN   = 17'h00400;

  // ----------------------------------------------------------------
  // Register offsets, resets and field layout
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] MODE_OFS   = 16'h0000;  // Mode register offset.
  localparam logic [DATA_W-1:0] STAT_OFS   = 16'h0002;  // Interrupt status offset.
  localparam logic [DATA_W-1:0] STAT_RESET = 16'h0000;  // Interrupt status reset.
  localparam logic [DATA_W-1:0] PTR_RESET  = 16'h0000;  // Pointer reset.
  localparam logic [DATA_W-1:0] W1C_MASK   = 16'hF000;  // Host-cleared event bits.
  localparam logic [DATA_W-1:0] RSVD_MASK  = 16'h0F00;  // Reserved status bits.
  localparam logic [DATA_W-1:0] HALF_ALIGN = 16'hFFFE;  // Drops the offset LSB.
  localparam int BIT_CONFLICT = 15;  // Address conflict flag.
  localparam int BIT_UNREACH  = 14;  // Port unreachable flag.
  localparam int BIT_SESSION  = 13;  // Session closed flag.
  localparam int BIT_FRAGMENT = 12;  // Fragment size notice flag.

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  localparam logic [1:0] BE_WORD = 2'h3;  // Both bytes.
  localparam logic [1:0] BE_HIGH = 2'h2;  // Most significant byte.
  localparam logic [1:0] BE_LOW  = 2'h1;  // Least significant byte.

  // Source of read data held in the first pipeline stage.
  typedef enum logic [3:0] {
    SRC_NONE = 4'h1,
    SRC_PTR  = 4'h2,
    SRC_STAT = 4'h4,
    SRC_TGT  = 4'h8
  } iars_src_e;

endpackage

//--- logic/iars_stat_if.sv
`timescale 1ns/10ps
// Carries status register accesses from the decoder to the status logic.
interface iars_stat_if;
  logic        wr;     // One-cycle write strobe.
  logic [1:0]  be;     // Byte lanes of the write.
  logic [15:0] wdata;  // Write data in its lanes.
  logic [15:0] rdata;  // Current status value.
  logic        int_n;  // Host interrupt level, low active.
  modport ctrl (output wr, be, wdata, input rdata, int_n);
  modport stat (input wr, be, wdata, output rdata, int_n);
endinterface

//--- logic/iars_irq_status.sv
`timescale 1ns/10ps
// Interrupt status register and the host interrupt pin.
module iars_irq_status (
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     address_conflict_flag,
  input  wire logic                     port_unreachable_flag,
  input  wire logic                     session_closed_flag,
  input  wire logic                     fragment_size_notice_flag,
  input  wire logic [iars_pkg::SOCK_N-1:0] socket_raise,
  input  wire logic [iars_pkg::SOCK_N-1:0] socket_event_status,
  input  wire logic [15:0]              interrupt_enable_mask,
  iars_stat_if.stat                     bus
);

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  logic [15:0] status_q;   // Interrupt status.
  logic [15:0] status_d;   // Next interrupt status.
  logic [15:0] set_vec;    // Events of this cycle.
  logic [15:0] w1c_vec;    // Bits the host clears by writing one.
  logic [15:0] auto_clr;   // Summary bits whose socket has gone quiet.
  logic        int_n_q;    // Interrupt pin level.

  // Collects the events; set always wins over any clear.
  always_comb begin
    set_vec = {address_conflict_flag, port_unreachable_flag, session_closed_flag,
               fragment_size_notice_flag, 4'h0, socket_raise};
    w1c_vec = (bus.wr && bus.be[1]) ? (bus.wdata & iars_pkg::W1C_MASK) : 16'h0000;
    auto_clr = {8'h00, ~socket_event_status};
    status_d = ((status_q & ~w1c_vec & ~auto_clr) | set_vec) & ~iars_pkg::RSVD_MASK;
  end

  // Holds the status bits.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= iars_pkg::STAT_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Drives the pin low on a masked bit, high again only when all bits are zero.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      int_n_q <= 1'b1;
    end else if (|(status_q & interrupt_enable_mask)) begin
      int_n_q <= 1'b0;
    end else if (status_q == 16'h0000) begin
      int_n_q <= 1'b1;
    end
  end

  assign bus.rdata = status_q;
  assign bus.int_n = int_n_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_event_sets_bit: assert property (
    address_conflict_flag |=> status_q[iars_pkg::BIT_CONFLICT])
    else $error("Conflict event did not set its status bit.");
  a_w1c_clears: assert property (
    bus.wr && bus.be[1] && bus.wdata[iars_pkg::BIT_UNREACH] && !port_unreachable_flag
    |=> !status_q[iars_pkg::BIT_UNREACH])
    else $error("Write of one did not clear the flag.");
  a_zero_keeps: assert property (
    status_q[iars_pkg::BIT_SESSION] && !(bus.wr && bus.be[1] && bus.wdata[iars_pkg::BIT_SESSION])
    |=> status_q[iars_pkg::BIT_SESSION])
    else $error("Flag cleared without a write of one.");
  a_sock_autoclear: assert property (
    1'b1 |=> ((status_q[7:0] & ~$past(socket_event_status) & ~$past(socket_raise)) == 8'h00))
    else $error("Socket summary bit outlived its socket status.");
  a_reserved_zero: assert property (
    (status_q & iars_pkg::RSVD_MASK) == 16'h0000)
    else $error("Reserved status bits are not zero.");
  a_pin_asserts: assert property (
    |(status_q & interrupt_enable_mask) |=> !int_n_q)
    else $error("Masked status bit did not pull the pin low.");
  a_pin_holds: assert property (
    !int_n_q && status_q != 16'h0000 |=> !int_n_q)
    else $error("Pin released while status bits remain.");

endmodule // iars_irq_status

//--- logic/iars_top.sv
`timescale 1ns/10ps
// What this block does
// - Pointer mode exposes only mode, pointer, window.
// - Pointer holds target offset, LSB ignored.
// - Window access acts on pointed register.
// - High byte maps to register MSB.
// - Width select picks word or byte transfers.
// - Status bit sets when its event occurs.
// - Masked set status bit pulls pin low.
// - Pin stays low until status is zero.
// - Upper status bits clear on written one.
// - Socket summary clears when socket status clears.
// - Bit 15 flags address conflict.
// - Bit 14 flags port unreachable message.
// - Bit 13 flags closed session.
// - Bit 12 flags fragment size notice.
// - Bits 7..0 follow socket interrupts.
// - Mask bit gates same status bit.
module iars_top (
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic [iars_pkg::ADDR_W-1:0] host_addr,
  input  wire logic                       host_rd,
  input  wire logic                       host_wr,
  input  wire logic [15:0]                host_wdata,
  output      logic [15:0]                host_rdata,
  output      logic                       host_rvalid,
  output      logic                       host_int_n,
  input  wire logic                       pointer_access_select,
  input  wire logic                       bus_width_select,
  input  wire logic [15:0]                interrupt_enable_mask,
  input  wire logic                       address_conflict_flag,
  input  wire logic                       port_unreachable_flag,
  input  wire logic                       session_closed_flag,
  input  wire logic                       fragment_size_notice_flag,
  input  wire logic [iars_pkg::SOCK_N-1:0] socket_raise,
  input  wire logic [iars_pkg::SOCK_N-1:0] socket_event_status,
  output      logic                       tgt_rd,
  output      logic                       tgt_wr,
  output      logic [15:0]                tgt_addr,
  output      logic [1:0]                 tgt_be,
  output      logic [15:0]                tgt_wdata,
  input  wire logic [15:0]                tgt_rdata
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Byte lanes of a host access: a word, or one byte chosen by address bit 0.
  function automatic logic [1:0] lane_be(input logic wide, input logic a0);
    if (wide) begin
      lane_be = iars_pkg::BE_WORD;
    end else if (a0) begin
      lane_be = iars_pkg::BE_LOW;
    end else begin
      lane_be = iars_pkg::BE_HIGH;
    end
  endfunction

  // Returns the word, or the one selected byte in the low lane.
  function automatic logic [15:0] byte_pick(input logic [1:0] be, input logic [15:0] w);
    if (be == iars_pkg::BE_WORD) begin
      byte_pick = w;
    end else if (be == iars_pkg::BE_HIGH) begin
      byte_pick = {8'h00, w[15:8]};
    end else begin
      byte_pick = {8'h00, w[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [iars_pkg::ADDR_W-1:0] word_addr;  // Host address with bit 0 cleared.
  logic [1:0]                  acc_be;     // Byte lanes of this access.
  logic [15:0]                 acc_wdata;  // Write data placed in its lanes.
  logic                        hit_ptr;    // Pointer register addressed.
  logic                        hit_tgt;    // A common or socket register addressed.
  logic [15:0]                 tgt_ofs;    // Offset of that register.
  logic                        acc_rd;     // Read taken this cycle.
  logic                        acc_wr;     // Write taken this cycle.
  logic [15:0]                 ptr_q;      // Pointer register.

  // Decodes the host access; a write wins over a read in the same cycle.
  always_comb begin
    acc_wr = host_wr;
    acc_rd = host_rd && !host_wr;
    word_addr = {host_addr[iars_pkg::ADDR_W-1:1], 1'b0};
    acc_be = lane_be(bus_width_select, host_addr[0]);
    acc_wdata = bus_width_select ? host_wdata : {host_wdata[7:0], host_wdata[7:0]};
    hit_ptr = (word_addr == iars_pkg::PTR_ADDR);
    hit_tgt = 1'b0;
    tgt_ofs = iars_pkg::MODE_OFS;
    if (pointer_access_select) begin
      if (word_addr == iars_pkg::WIN_ADDR) begin
        hit_tgt = 1'b1;
        tgt_ofs = ptr_q & iars_pkg::HALF_ALIGN;
      end else if (word_addr == iars_pkg::MODE_PTR_ADDR) begin
        hit_tgt = 1'b1;
        tgt_ofs = iars_pkg::MODE_OFS;
      end
    end else if (word_addr < iars_pkg::DIRECT_SPAN) begin
      hit_tgt = 1'b1;
      tgt_ofs = word_addr[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Pointer register
  // ----------------------------------------------------------------

  // Loads the pointer bytes that the access covers; byte writes may come in either order.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= iars_pkg::PTR_RESET;
    end else if (acc_wr && hit_ptr) begin
      if (acc_be[1]) begin
        ptr_q[15:8] <= acc_wdata[15:8];
      end
      if (acc_be[0]) begin
        ptr_q[7:0] <= acc_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Forwarding stage
  // ----------------------------------------------------------------
  iars_stat_if          st_bus ();  // Link to the status logic.
  logic                 stat_wr_q;  // Status write strobe.
  logic [1:0]           stat_be_q;  // Status write lanes.
  logic [15:0]          stat_wd_q;  // Status write data.
  logic                 tgt_rd_q;   // Target read strobe.
  logic                 tgt_wr_q;   // Target write strobe.
  logic [15:0]          tgt_addr_q; // Target offset.
  logic [1:0]           tgt_be_q;   // Target lanes.
  logic [15:0]          tgt_wd_q;   // Target write data.
  logic                 rd1_q;      // A read is in the first stage.
  logic [1:0]           be1_q;      // Its lanes.
  iars_pkg::iars_src_e  src1_q;     // Where its data comes from.
  logic                 is_stat;    // Target is the local status register.

  assign is_stat = hit_tgt && (tgt_ofs == iars_pkg::STAT_OFS);

  // Sends status writes to the local register, whatever path they came by.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stat_wr_q <= 1'b0;
      stat_be_q <= iars_pkg::BE_WORD;
      stat_wd_q <= 16'h0000;
    end else begin
      stat_wr_q <= acc_wr && is_stat;
      stat_be_q <= acc_be;
      stat_wd_q <= acc_wdata;
    end
  end

  // Forwards every other register access to the register port.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tgt_rd_q   <= 1'b0;
      tgt_wr_q   <= 1'b0;
      tgt_addr_q <= iars_pkg::MODE_OFS;
      tgt_be_q   <= iars_pkg::BE_WORD;
      tgt_wd_q   <= 16'h0000;
    end else begin
      tgt_rd_q <= acc_rd && hit_tgt && !is_stat;
      tgt_wr_q <= acc_wr && hit_tgt && !is_stat;
      if ((acc_rd || acc_wr) && hit_tgt) begin
        tgt_addr_q <= tgt_ofs;
        tgt_be_q   <= acc_be;
        tgt_wd_q   <= acc_wdata;
      end
    end
  end

  // Remembers what a read must return; unmapped reads return zero.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd1_q  <= 1'b0;
      be1_q  <= iars_pkg::BE_WORD;
      src1_q <= iars_pkg::SRC_NONE;
    end else begin
      rd1_q <= acc_rd;
      be1_q <= acc_be;
      if (is_stat) begin
        src1_q <= iars_pkg::SRC_STAT;
      end else if (hit_tgt) begin
        src1_q <= iars_pkg::SRC_TGT;
      end else if (hit_ptr) begin
        src1_q <= iars_pkg::SRC_PTR;
      end else begin
        src1_q <= iars_pkg::SRC_NONE;
      end
    end
  end

  assign st_bus.wr    = stat_wr_q;
  assign st_bus.be    = stat_be_q;
  assign st_bus.wdata = stat_wd_q;

  assign tgt_rd    = tgt_rd_q;
  assign tgt_wr    = tgt_wr_q;
  assign tgt_addr  = tgt_addr_q;
  assign tgt_be    = tgt_be_q;
  assign tgt_wdata = tgt_wd_q;

  // ----------------------------------------------------------------
  // Read answer stage
  // ----------------------------------------------------------------
  logic [15:0] rd_word;       // Word chosen for the read.
  logic [15:0] host_rdata_q;  // Read data to the host.
  logic        host_rvalid_q; // Read data valid.

  // Picks the source word of the pending read.
  always_comb begin
    case (src1_q)
      iars_pkg::SRC_PTR:  rd_word = ptr_q;
      iars_pkg::SRC_STAT: rd_word = st_bus.rdata;
      iars_pkg::SRC_TGT:  rd_word = tgt_rdata;
      default:            rd_word = 16'h0000;
    endcase
  end

  // Returns the word, or the addressed byte in the low lane.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_rdata_q  <= 16'h0000;
      host_rvalid_q <= 1'b0;
    end else begin
      host_rvalid_q <= rd1_q;
      if (rd1_q) begin
        host_rdata_q <= byte_pick(be1_q, rd_word);
      end
    end
  end

  assign host_rdata  = host_rdata_q;
  assign host_rvalid = host_rvalid_q;
  assign host_int_n  = st_bus.int_n;

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------

  iars_irq_status u_status (
    .core_clk                  (core_clk),
    .resetn                    (resetn),
    .address_conflict_flag     (address_conflict_flag),
    .port_unreachable_flag     (port_unreachable_flag),
    .session_closed_flag       (session_closed_flag),
    .fragment_size_notice_flag (fragment_size_notice_flag),
    .socket_raise              (socket_raise),
    .socket_event_status       (socket_event_status),
    .interrupt_enable_mask     (interrupt_enable_mask),
    .bus                       (st_bus.stat)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_read_taken;
    host_rd && !host_wr;
  endsequence

  sequence s_read_answered;
    ##2 host_rvalid_q;
  endsequence

  a_read_latency: assert property (
    s_read_taken |-> s_read_answered)
    else $error("Read was not answered two cycles later.");
  a_window_target: assert property (
    pointer_access_select && host_wr && word_addr == iars_pkg::WIN_ADDR
    && (ptr_q & iars_pkg::HALF_ALIGN) != iars_pkg::STAT_OFS
    |=> tgt_wr_q && tgt_addr_q == ($past(ptr_q) & iars_pkg::HALF_ALIGN))
    else $error("Window write did not reach the pointed register.");
  a_window_status: assert property (
    pointer_access_select && host_wr && word_addr == iars_pkg::WIN_ADDR
    && (ptr_q & iars_pkg::HALF_ALIGN) == iars_pkg::STAT_OFS |=> stat_wr_q && !tgt_wr_q)
    else $error("Window write to status took another path.");
  a_direct_no_win: assert property (
    !pointer_access_select && host_wr && word_addr == iars_pkg::WIN_ADDR
    |=> !tgt_wr_q && !stat_wr_q)
    else $error("Window redirected an access in direct mode.");
  a_pointer_only: assert property (
    pointer_access_select && host_wr && word_addr < iars_pkg::DIRECT_SPAN
    |=> !tgt_wr_q && !stat_wr_q)
    else $error("Direct address decoded in pointer mode.");
  a_byte_read: assert property (
    host_rd && !host_wr && !bus_width_select |-> ##2 host_rdata_q[15:8] == 8'h00)
    else $error("Byte read returned data in the upper lane.");

endmodule // iars_top

//--- verif/iars_tgt_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Register space behind the pointer window
// ----------------------------------------------------------------
module iars_tgt_model (
  input  wire logic        core_clk,
  input  wire logic        tgt_rd,
  input  wire logic        tgt_wr,
  input  wire logic [15:0] tgt_addr,
  input  wire logic [1:0]  tgt_be,
  input  wire logic [15:0] tgt_wdata,
  output      logic [15:0] tgt_rdata
);
  logic [15:0] mem_q [0:511];  // Halfword registers; offset bit 0 is unused.
  // Writes land lane by lane, so a byte write leaves the other byte alone.
  always @(posedge core_clk) begin
    if (tgt_wr) begin
      if (tgt_be[1]) mem_q[tgt_addr[9:1]][15:8] <= tgt_wdata[15:8];
      if (tgt_be[0]) mem_q[tgt_addr[9:1]][7:0] <= tgt_wdata[7:0];
    end
  end
  // Outside a read the lines show the inverse, so stale data never matches.
  assign tgt_rdata = tgt_rd ? mem_q[tgt_addr[9:1]] : ~mem_q[tgt_addr[9:1]];
endmodule // iars_tgt_model

//--- verif/iars_top_tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bench for the pointer window and the interrupt status register
// ----------------------------------------------------------------
module iars_top_tb;
  logic        core_clk, resetn;     // Clock and low-active reset.
  logic [16:0] host_addr;            // Host byte address.
  logic        host_rd, host_wr;     // Host strobes.
  logic [15:0] host_wdata, host_rdata;  // Host data.
  logic        host_rvalid, host_int_n; // Read marker and pin.
  logic        ptr_sel, bw_sel;      // Mode bits.
  logic [15:0] mask;                 // Interrupt enable mask.
  logic [3:0]  ev;                   // Event pulses for bits 15..12.
  logic [7:0]  sraise, sstat;        // Socket raise pulses and levels.
  logic        tgt_rd, tgt_wr;       // Target strobes.
  logic [15:0] tgt_addr, tgt_wdata, tgt_rdata; // Target bus.
  logic [1:0]  tgt_be;               // Target lanes.
  logic [15:0] exp_q [$];            // Expected read answers, oldest first.
  logic [15:0] d, st;                // Random data and expected status.
  int          err_total, n_checks, cyc;
  iars_top DUT (.core_clk(core_clk), .resetn(resetn), .host_addr(host_addr),
    .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .host_int_n(host_int_n),
    .pointer_access_select(ptr_sel), .bus_width_select(bw_sel),
    .interrupt_enable_mask(mask), .address_conflict_flag(ev[3]),
    .port_unreachable_flag(ev[2]), .session_closed_flag(ev[1]),
    .fragment_size_notice_flag(ev[0]), .socket_raise(sraise),
    .socket_event_status(sstat), .tgt_rd(tgt_rd), .tgt_wr(tgt_wr),
    .tgt_addr(tgt_addr), .tgt_be(tgt_be), .tgt_wdata(tgt_wdata),
    .tgt_rdata(tgt_rdata));
  iars_tgt_model u_tgt (.core_clk(core_clk), .tgt_rd(tgt_rd), .tgt_wr(tgt_wr),
    .tgt_addr(tgt_addr), .tgt_be(tgt_be), .tgt_wdata(tgt_wdata),
    .tgt_rdata(tgt_rdata));
  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  // The clock toggles every 4 ns for a 125 MHz rate.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // A hang is cut short after far more cycles than the tests need.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      results();
    end
  end
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
    n_checks++;
    if (seen !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // One host write pulse, driven at the falling edge.
  task automatic hw(input logic [16:0] a, input logic [15:0] v);
    @(negedge core_clk);
    host_addr = a;
    host_wdata = v;
    host_wr = 1'b1;
    @(negedge core_clk);
    host_wr = 1'b0;
  endtask
  // One host read pulse; the answer expected is noted for the watcher.
  task automatic hr(input logic [16:0] a, input logic [15:0] e);
    @(negedge core_clk);
    host_addr = a;
    host_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge core_clk);
    host_rd = 1'b0;
  endtask
  // One cycle of event and socket pulses.
  task automatic pulse(input logic [3:0] e, input logic [7:0] s);
    @(negedge core_clk);
    ev = e;
    sraise = s;
    @(negedge core_clk);
    ev = 4'h0;
    sraise = 8'h00;
  endtask
  // Takes the oldest note whenever a read answer is marked.
  always @(negedge core_clk) begin
    if (host_rvalid === 1'b1) begin
      if (exp_q.size() != 0) chk("host_rdata", host_rdata, exp_q.pop_front());
      else chk("unexpected answer", 16'h0001, 16'h0000);
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {resetn, host_rd, host_wr, host_addr, host_wdata} = '0;
    {ptr_sel, bw_sel, mask, ev, sraise, sstat, err_total, n_checks, cyc} = '0;
    ptr_sel = 1'b1;
    bw_sel = 1'b1;
    d = 16'($urandom(32'hE145));
    d = 16'($urandom());
    idle(20);
    resetn = 1'b1;
    hr(iars_pkg::PTR_ADDR, iars_pkg::PTR_RESET);
    chk("int_n reset", {15'h0000, host_int_n}, 16'h0001);
    // Word window write and read back; the odd pointer bit is dropped.
    hw(iars_pkg::PTR_ADDR, 16'h0031);
    hw(iars_pkg::WIN_ADDR, d);
    chk("tgt_addr", tgt_addr, 16'h0030);
    // A direct address written in pointer mode must not reach the register.
    hw(17'h00030, 16'hFFFF);
    hr(iars_pkg::WIN_ADDR, d);
    hr(17'h00030, 16'h0000);
    // The mode register stays reachable and is forwarded as a one-cycle write.
    hw(iars_pkg::MODE_PTR_ADDR, 16'h0101);
    chk("tgt_wr", {15'h0000, tgt_wr}, 16'h0001);
    chk("tgt_addr mode", tgt_addr, iars_pkg::MODE_OFS);
    idle(1);
    chk("tgt_wr end", {15'h0000, tgt_wr}, 16'h0000);
    hr(iars_pkg::MODE_PTR_ADDR, 16'h0101);
    // Byte host: pointer in two bytes, high byte first, then lanes.
    bw_sel = 1'b0;
    hw(iars_pkg::PTR_ADDR, 16'h0000);
    hw(iars_pkg::PTR_ADDR | 17'h00001, 16'h0030);
    hr(iars_pkg::WIN_ADDR, {8'h00, d[15:8]});
    hr(iars_pkg::WIN_ADDR | 17'h00001, {8'h00, d[7:0]});
    hw(iars_pkg::WIN_ADDR | 17'h00001, 16'h00A5);
    chk("tgt_be", {14'h0000, tgt_be}, 16'h0001);
    chk("tgt_wdata", tgt_wdata, 16'hA5A5);
    hr(iars_pkg::WIN_ADDR, {8'h00, d[15:8]});
    hr(iars_pkg::WIN_ADDR | 17'h00001, 16'h00A5);
    bw_sel = 1'b1;
    // Events set status; only masked bits pull the pin.
    hw(iars_pkg::PTR_ADDR, iars_pkg::STAT_OFS);
    mask = 16'h4000;
    pulse(4'h1, 8'h00);
    idle(2);
    chk("int_n unmasked", {15'h0000, host_int_n}, 16'h0001);
    pulse(4'h4, 8'h00);
    idle(2);
    chk("int_n masked", {15'h0000, host_int_n}, 16'h0000);
    for (int i = 0; i < 4; i++) pulse(4'(1 << i), 8'h00);
    d = 16'($urandom()) | 16'h0001;
    sstat = d[7:0];
    pulse(4'h0, d[7:0]);
    st = 16'hF000 | {8'h00, d[7:0]};
    idle(2);
    hr(iars_pkg::WIN_ADDR, st);
    hw(iars_pkg::WIN_ADDR, 16'h0FFF);
    idle(2);
    hr(iars_pkg::WIN_ADDR, st);
    mask = 16'h0000;
    hw(iars_pkg::WIN_ADDR, 16'h3000);
    idle(2);
    chk("int_n held", {15'h0000, host_int_n}, 16'h0000);
    hr(iars_pkg::WIN_ADDR, st & 16'hCFFF);
    idle(2);
    // Direct mode reaches status at its own address.
    ptr_sel = 1'b0;
    idle(2);
    hr(17'h00002, st & 16'hCFFF);
    // A window write in direct mode must leave the status untouched.
    hw(iars_pkg::WIN_ADDR, 16'hC000);
    hr(17'h00002, st & 16'hCFFF);
    hw(17'h00002, 16'hC000);
    hr(iars_pkg::WIN_ADDR, 16'h0000);
    idle(2);
    hr(17'h00002, {8'h00, d[7:0]});
    sstat = 8'h00;
    idle(3);
    hr(17'h00002, 16'h0000);
    idle(2);
    chk("int_n released", {15'h0000, host_int_n}, 16'h0001);
    hw(17'h00030, 16'h5A5A);
    ptr_sel = 1'b1;
    idle(2);
    hw(iars_pkg::PTR_ADDR, 16'h0030);
    hr(iars_pkg::WIN_ADDR, 16'h5A5A);
    idle(4);
    chk("reads pending", 16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule // iars_top_tb
